// ===== rtl/sids_split_status.sv
// Split interrupt descriptor: masks, per-microframe counts and status
// Notes on behaviour
// - Each microframe's 8-bit count is recorded only for an IN result when its start mask bit is set and the frame matches.
// - A new reception result overwrites the stored count rather than adding to it.
// - Counts 6..3 sit in bits 31-0 of word 6 and counts 2..0 in bits 63-40 of word 5; count 7 in bits 39-32 of word 7.
// - Software sets complete-split mask bits and the block clears each bit once its microframe is processed for an IN transfer.
// - Mask bit n addresses microframe n for both start and complete splits.
// - A 3-bit status per microframe is packed in bits 31-8 of word 4, microframe 7 highest.
// - Status bit 0 is transaction error, bit 1 babble for IN, bit 2 underrun for OUT.
// - Software sets start-split mask bits and the block clears each bit once its microframe is processed.
`timescale 1ns/1ns
`default_nettype none
`include "sids_map.svh"
module sids_split_status
    import sids_pkg::*;
#(
    parameter int NUM_UF  = 8,
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // Software mask loads (set bits only)
    input  wire logic                  ss_set_i,
    input  wire logic [NUM_UF-1:0]     ss_set_bits_i,
    input  wire logic                  cs_set_i,
    input  wire logic [NUM_UF-1:0]     cs_set_bits_i,
    // Bus schedule
    input  wire logic                  uframe_tick_i,
    input  wire logic [2:0]            uframe_num_i,
    input  wire logic                  frame_match_i,
    input  wire sids_pkg::sids_dir_type dir_i,
    // Transaction result for the current microframe
    input  wire logic                  result_valid_i,
    input  wire logic [COUNT_W-1:0]    result_count_i,
    input  wire logic                  result_xact_err_i,
    input  wire logic                  result_babble_i,
    input  wire logic                  result_underrun_i,
    // Split issue strobes
    output logic                       start_split_o,
    output logic                       complete_split_o,
    // Descriptor image
    output logic [NUM_UF-1:0]          start_split_mask_o,
    output logic [NUM_UF-1:0]          complete_split_mask_o,
    output logic [31:0]                descriptor_word4_o,
    output logic [63:0]                descriptor_word5_o,
    output logic [31:0]                descriptor_word6_o,
    output logic [63:0]                descriptor_word7_o
);
    import sids_pkg::*;

    // Refuse layouts that the descriptor packing cannot serve
    if (NUM_UF != `SIDS_NUM_UFRAMES || COUNT_W != `SIDS_COUNT_W) begin : g_bad_layout
        $error("descriptor layout fixes 8 microframes of 8-bit counts");
    end

    // ------------------------------------------------------------
    // Microframe decode
    // ------------------------------------------------------------
    // One-hot select of microframe n
    function automatic logic [NUM_UF-1:0] uf_sel(input logic [2:0] n);
        uf_sel = '0;
        uf_sel[n] = 1'b1;
    endfunction : uf_sel

    logic [NUM_UF-1:0] cur_sel;
    logic              ss_hit;
    logic              cs_hit;
    logic              dir_in;
    logic [NUM_UF-1:0] start_split_mask_reg;
    logic [NUM_UF-1:0] complete_split_mask_reg;
    logic [NUM_UF-1:0] slot_wr;

    assign dir_in  = (dir_i == SIDS_PID_IN);
    assign cur_sel = uf_sel(uframe_num_i);
    assign ss_hit  = frame_match_i && |(start_split_mask_reg & cur_sel);
    // Complete splits exist only for IN
    assign cs_hit  = frame_match_i && dir_in && |(complete_split_mask_reg & cur_sel);

    // ------------------------------------------------------------
    // Split masks
    // ------------------------------------------------------------
    // Processing clear beats nothing: a software set in the same cycle wins
    // start mask set and clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_split_mask_reg <= `SIDS_MASK_RST;
        end else begin
            start_split_mask_reg <= (start_split_mask_reg
                                     & ~((uframe_tick_i && ss_hit) ? cur_sel : '0))
                                    | (ss_set_i ? ss_set_bits_i : '0);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            complete_split_mask_reg <= `SIDS_MASK_RST;
        end else begin
            complete_split_mask_reg <= (complete_split_mask_reg
                                        & ~((uframe_tick_i && cs_hit) ? cur_sel : '0))
                                       | (cs_set_i ? cs_set_bits_i : '0);
        end
    end

    // Split issue strobes, one cycle after the tick
    // issue in selected microframe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_split_o    <= 1'b0;
            complete_split_o <= 1'b0;
        end else begin
            start_split_o    <= uframe_tick_i && ss_hit;
            complete_split_o <= uframe_tick_i && cs_hit;
        end
    end

    assign start_split_mask_o    = start_split_mask_reg;
    assign complete_split_mask_o = complete_split_mask_reg;

    // ------------------------------------------------------------
    // Per-microframe result slots
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] slot_count [NUM_UF];
    logic [2:0]         slot_status [NUM_UF];
    logic [3*NUM_UF-1:0] status_flat;

    // record only on enabled matching microframe
    assign slot_wr = (result_valid_i && frame_match_i)
                     ? (cur_sel & start_split_mask_reg) : '0;

    for (genvar g = 0; g < NUM_UF; g++) begin : g_slot
        sids_uframe_slot #(
            .COUNT_W(COUNT_W)
        ) u_slot (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .wr_i      (slot_wr[g]),
            .dir_in_i  (dir_in),
            .count_i   (result_count_i),
            .xact_err_i(result_xact_err_i),
            .babble_i  (result_babble_i),
            .underrun_i(result_underrun_i),
            .count_o   (slot_count[g]),
            .status_o  (slot_status[g])
        );
    end

    // ------------------------------------------------------------
    // Descriptor packing
    // ------------------------------------------------------------
    // Status fields packed contiguously, microframe 7 highest
    // status packing
    always_comb begin
        status_flat = '0;
        for (int i = 0; i < NUM_UF; i++) begin
            status_flat[3*i +: 3] = slot_status[i];
        end
    end
    assign descriptor_word4_o = {status_flat, start_split_mask_reg};
    assign descriptor_word5_o = {slot_count[2], slot_count[1], slot_count[0],
                                 complete_split_mask_reg, 32'h0000_0000};
    assign descriptor_word6_o = {slot_count[6], slot_count[5], slot_count[4], slot_count[3]};
    assign descriptor_word7_o = {24'h00_0000, slot_count[7], 32'h0000_0000};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_count_capture: assert property (
        slot_wr[0] && dir_in |=> descriptor_word5_o[47:40] == $past(result_count_i))
        else $error("count 0 not captured");
    chk_count_blocked: assert property (
        !(start_split_mask_reg[3] && frame_match_i) |=> $stable(descriptor_word6_o[7:0]))
        else $error("count 3 changed without enable");
    chk_count_overwrite: assert property (
        slot_wr[1] && dir_in |=> descriptor_word5_o[55:48] == $past(result_count_i))
        else $error("count 1 not overwritten");
    chk_word5_place: assert property (
        slot_wr[2] && dir_in |=> descriptor_word5_o[63:56] == $past(result_count_i) && descriptor_word5_o[31:0] == '0)
        else $error("count 2 misplaced");
    chk_cs_clear: assert property (
        uframe_tick_i && cs_hit && !cs_set_i |=> !complete_split_mask_reg[$past(uframe_num_i)])
        else $error("complete mask bit not cleared");
    chk_ss_issue: assert property (
        uframe_tick_i && frame_match_i && start_split_mask_reg[uframe_num_i] |=> start_split_o)
        else $error("start split not issued");
    chk_cs_issue: assert property (
        uframe_tick_i && frame_match_i && dir_in && complete_split_mask_reg[2] && uframe_num_i == 3'h2
        |=> complete_split_o ##1 !complete_split_o || uframe_tick_i)
        else $error("complete split not issued in microframe 2");
    chk_status_place: assert property (
        slot_wr[7] |=> descriptor_word4_o[31] == ($past(result_underrun_i) && !$past(dir_in)))
        else $error("status 7 misplaced");
    chk_babble_in_only: assert property (
        slot_wr[4] && !dir_in |=> !descriptor_word4_o[21])
        else $error("babble flagged on OUT");
    chk_ss_clear: assert property (
        uframe_tick_i && ss_hit && !ss_set_i |=> !start_split_mask_reg[$past(uframe_num_i)])
        else $error("start mask bit not cleared");

    cov_ss_then_cs: cover property (start_split_o ##[1:20] complete_split_o);
    cov_in_result:  cover property (|slot_wr && dir_in);
    cov_out_result: cover property (|slot_wr && !dir_in);
endmodule : sids_split_status
`default_nettype wire

// ===== rtl/sids_map.svh
// Field positions, reset values and counts of the split interrupt descriptor words
`ifndef SIDS_MAP_SVH
`define SIDS_MAP_SVH
// Microframes per frame
`define SIDS_NUM_UFRAMES      8
// Width of one received-count field
`define SIDS_COUNT_W          8
// Width of one status field
`define SIDS_STATUS_W         3
// Status field bit positions
`define SIDS_ST_XACT_ERR      0
`define SIDS_ST_BABBLE        1
`define SIDS_ST_UNDERRUN      2
// Lowest bit of status field 0 within descriptor word 4 (low half)
`define SIDS_STATUS_LSB       8
// Lowest bit of count field 0 within the word pair 5 (upper half)
`define SIDS_CNT0_LSB         40
// Lowest bit of the complete-split mask in the word pair 5
`define SIDS_CSMASK_LSB       32
// Reset values
`define SIDS_MASK_RST         8'h00
`define SIDS_COUNT_RST        8'h00
`define SIDS_STATUS_RST       3'h0
`endif

// ===== rtl/sids_pkg.sv
// Types shared by the split interrupt descriptor status block
package sids_pkg;
    typedef enum logic [1:0] {
        SIDS_PID_OUT = 2'h0,
        SIDS_PID_IN  = 2'h1
    } sids_dir_type;
endpackage : sids_pkg

// ===== rtl/sids_uframe_slot.sv
// One microframe slot: received count and status field storage
`timescale 1ns/1ns
`default_nettype none
`include "sids_map.svh"
module sids_uframe_slot #(
    parameter int COUNT_W = 8
) (
    // Clock and reset
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    // Result write
    input  wire logic               wr_i,
    input  wire logic               dir_in_i,
    input  wire logic [COUNT_W-1:0] count_i,
    input  wire logic               xact_err_i,
    input  wire logic               babble_i,
    input  wire logic               underrun_i,
    // Stored fields
    output logic      [COUNT_W-1:0] count_o,
    output logic      [2:0]         status_o
);
    // Refuse a count width the slot cannot hold
    if (COUNT_W < 1) begin : g_bad_width
        $error("COUNT_W must be positive");
    end

    // Count is replaced, never accumulated
    // overwrite on result
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else if (wr_i && dir_in_i) begin
            count_o <= count_i;
        end
    end

    // Babble and underrun bits qualified by direction
    // status bit meaning
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_o <= `SIDS_STATUS_RST;
        end else if (wr_i) begin
            status_o[`SIDS_ST_XACT_ERR] <= xact_err_i;
            status_o[`SIDS_ST_BABBLE]   <= dir_in_i & babble_i;
            status_o[`SIDS_ST_UNDERRUN] <= ~dir_in_i & underrun_i;
        end
    end
endmodule : sids_uframe_slot
`default_nettype wire

// ===== tb/sids_dev_model.sv
// Far-side interrupt device model that returns split results
`timescale 1ns/1ns
`default_nettype none
module sids_dev_model (
    // Clock and request from the bench
    input  wire logic       clk_i,
    input  wire logic       req_i,
    input  wire logic [3:0] lag_i,
    input  wire logic [7:0] count_i,
    input  wire logic [2:0] flags_i,
    // Result towards the block
    output logic            valid_o,
    output logic [7:0]      count_o,
    output logic [2:0]      flags_o
);
    logic [7:0] c;
    logic [2:0] f;
    // Answer after lag cycles; idle lines carry the inverse of the last value
    initial begin
        valid_o = 1'b0;
        count_o = 8'h00;
        flags_o = 3'h0;
        forever begin
            @(posedge clk_i);
            if (req_i) begin
                c = count_i;
                f = flags_i;
                repeat (lag_i) @(posedge clk_i);
                #1;
                valid_o = 1'b1;
                count_o = c;
                flags_o = f;
                @(posedge clk_i);
                #1;
                valid_o = 1'b0;
                count_o = ~c;
                flags_o = ~f;
            end
        end
    end
endmodule : sids_dev_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the split interrupt descriptor status block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import sids_pkg::*;
    typedef struct { int sel; logic [63:0] exp; } sids_exp_type;
    // ----------------------------------------
    // Signals and expected state
    // ----------------------------------------
    logic         clk, rst, ss_set, cs_set, tick, match, req, r_valid, s_o, c_o, es, ec;
    logic [7:0]   ss_bits, cs_bits, rq_cnt, r_cnt, ssm, csm, ess, ecs;
    logic [2:0]   num, rq_flg, r_flg;
    logic [3:0]   lag;
    logic [31:0]  w4, w6, seed;
    logic [63:0]  w5, w7;
    logic [7:0]   ecnt [8];
    logic [2:0]   est [8];
    sids_dir_type dir;
    sids_exp_type q [$];
    int           failures, checks;
    string        names [5] = '{"word4", "word5", "word6", "word7", "strobes_masks"};
    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    sids_dev_model dev_u (.clk_i(clk), .req_i(req), .lag_i(lag), .count_i(rq_cnt), .flags_i(rq_flg),
        .valid_o(r_valid), .count_o(r_cnt), .flags_o(r_flg));
    sids_split_status dut_u (.clk_i(clk), .rst_i(rst), .ss_set_i(ss_set), .ss_set_bits_i(ss_bits),
        .cs_set_i(cs_set), .cs_set_bits_i(cs_bits), .uframe_tick_i(tick), .uframe_num_i(num),
        .frame_match_i(match), .dir_i(dir), .result_valid_i(r_valid), .result_count_i(r_cnt),
        .result_xact_err_i(r_flg[0]), .result_babble_i(r_flg[1]), .result_underrun_i(r_flg[2]),
        .start_split_o(s_o), .complete_split_o(c_o), .start_split_mask_o(ssm), .complete_split_mask_o(csm),
        .descriptor_word4_o(w4), .descriptor_word5_o(w5), .descriptor_word6_o(w6), .descriptor_word7_o(w7));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [63:0] view(int sel);
        case (sel)
            0: return {32'h0, w4};
            1: return w5;
            2: return {32'h0, w6};
            3: return w7;
            default: return {46'h0, s_o, c_o, csm, ssm};
        endcase
    endfunction : view
    // Expected descriptor image built from the field layout
    function automatic logic [63:0] want(int sel);
        logic [63:0] e;
        e = '0;
        for (int i = 0; i < 8; i++) begin
            if (sel == 0) e[8+3*i+:3] = est[i];
            if (sel == 1 && i < 3) e[40+8*i+:8] = ecnt[i];
            if (sel == 2 && i >= 3 && i < 7) e[8*(i-3)+:8] = ecnt[i];
        end
        case (sel)
            0: e[7:0] = ess;
            1: e[39:32] = ecs;
            3: e[39:32] = ecnt[7];
            4: e[17:0] = {es, ec, ecs, ess};
            default: ;
        endcase
        return e;
    endfunction : want
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic expect_all();
        for (int s = 0; s < 5; s++) q.push_back('{s, want(s)});
    endtask : expect_all
    task automatic set_masks(input logic [7:0] s, input logic [7:0] c);
        ss_set = 1'b1;
        ss_bits = s;
        cs_set = 1'b1;
        cs_bits = c;
        step();
        ss_set = 1'b0;
        cs_set = 1'b0;
        ess = ess | s;
        ecs = ecs | c;
        expect_all();
    endtask : set_masks
    task automatic tick_at(input logic [2:0] n);
        num = n;
        tick = 1'b1;
        step();
        tick = 1'b0;
        es = match & ess[n];
        ec = match & ecs[n] & (dir == SIDS_PID_IN);
        ess[n] = ess[n] & ~es;
        ecs[n] = ecs[n] & ~ec;
        expect_all();
        es = 1'b0;
        ec = 1'b0;
        step();
        expect_all();
    endtask : tick_at
    task automatic result(input logic [2:0] n, input logic [3:0] l);
        logic [31:0] r;
        r = rnd();
        num = n;
        lag = l;
        rq_cnt = r[15:8];
        rq_flg = r[2:0];
        req = 1'b1;
        step();
        req = 1'b0;
        repeat (l + 1) step();
        if (match && ess[n]) begin
            if (dir == SIDS_PID_IN) ecnt[n] = rq_cnt;
            est[n] = {rq_flg[2] & (dir == SIDS_PID_OUT), rq_flg[1] & (dir == SIDS_PID_IN), rq_flg[0]};
        end
        expect_all();
    endtask : result
    task automatic close_out();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Monitor: takes every queued note, oldest first, and compares each with the outputs
    always @(negedge clk) begin
        sids_exp_type t;
        while (q.size() > 0) begin
            t = q.pop_front();
            checks++;
            if (view(t.sel) !== t.exp) begin
                failures++;
                $display("[FAIL] %s exp %h got %h", names[t.sel], t.exp, view(t.sel));
            end
        end
    end
    // Watchdog
    initial begin
        #100000;
        failures++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst, ss_set, cs_set, tick, req, es, ec} = 7'h40;
        {ss_bits, cs_bits, rq_cnt, ess, ecs, num, rq_flg, lag} = '0;
        match = 1'b1;
        dir = SIDS_PID_IN;
        seed = 32'd17714;
        for (int i = 0; i < 8; i++) {ecnt[i], est[i]} = '0;
        repeat (3) step();
        rst = 1'b0;
        expect_all();
        set_masks(8'h01, 8'h04);
        for (int n = 0; n < 3; n++) tick_at(n[2:0]);
        // IN start bits only in 0 to 3
        set_masks(8'h0f, 8'h00);
        for (int n = 0; n < 4; n++) begin
            result(n[2:0], n[3:0]);
            result(n[2:0], 4'h0);
            tick_at(n[2:0]);
            result(n[2:0], 4'h1);
        end
        set_masks(8'h04, 8'h00);
        match = 1'b0;
        result(3'h2, 4'h0);
        tick_at(3'h2);
        match = 1'b1;
        dir = SIDS_PID_OUT;
        set_masks(8'hf0, 8'hf0);
        for (int n = 4; n < 8; n++) begin
            result(n[2:0], 4'h2);
            tick_at(n[2:0]);
        end
        tick_at(3'h2);
        step();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
